// [pkg/lcd_seg_pkg.sv]
// Purpose: shared constants for the segment panel controller
// Assumes: 8-bit processor data path, byte and single-bit writes
// Notes:   mode codes follow the display mode field encoding
package lcd_seg_pkg;
   localparam int        SEG_LINES     = 24;
   localparam int        COM_LINES     = 8;
   localparam int        SYNC_STAGES   = 3;
   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [15:0] ADDR_SUPPLY   = 16'hffb0;
   localparam logic [15:0] ADDR_DISP     = 16'hffb1;
   localparam logic [15:0] ADDR_CLK      = 16'hffb2;
   localparam logic [15:0] ADDR_MEM_BASE = 16'hfa40;
   // ----------------------------------------
   // reset values and writable masks
   // ----------------------------------------
   localparam logic [7:0] RST_SUPPLY    = 8'h00;
   localparam logic [7:0] RST_DISP      = 8'h00;
   localparam logic [7:0] RST_CLK       = 8'h00;
   localparam logic [7:0] MASK_SUPPLY   = 8'h30;
   localparam logic [7:0] MASK_DISP     = 8'hd7;
   localparam logic [7:0] MASK_CLK      = 8'h77;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int        SUPPLY_LSB    = 4;
   localparam int        DISP_ON_BIT   = 7;
   localparam int        PIN_CTRL_BIT  = 6;
   localparam int        BOOST_BIT     = 4;
   localparam int        SRC_SEL_LSB   = 4;
   // ----------------------------------------
   // display modes and supply choices
   // ----------------------------------------
   localparam logic [2:0] MODE_SLICE8   = 3'h7;
   localparam logic [2:0] MODE_SLICE4   = 3'h0;
   localparam logic [2:0] MODE_SLICE3_B3 = 3'h1;
   localparam logic [2:0] MODE_SLICE2   = 3'h2;
   localparam logic [2:0] MODE_SLICE3_B2 = 3'h3;
   localparam logic [2:0] MODE_STATIC   = 3'h4;
   localparam logic [1:0] SUP_EXTERNAL  = 2'h0;
   localparam logic [1:0] SUP_INT_FULL  = 2'h1;
   localparam logic [1:0] SUP_INT_STEP  = 2'h3;
   // ----------------------------------------
   // divider exponents
   // ----------------------------------------
   localparam int        REF_DIV_BASE  = 5;
   localparam int        SLOW_DIV_EXP  = 3;
   localparam int        CL_DIV_BASE   = 4;
   localparam int        CL_SEL_MAX    = 5;
endpackage : lcd_seg_pkg

// [src/lcd_segment_driver_control.sv]
// Purpose: segment panel controller: mode registers, display memory, scan
// Assumes: one 100 MHz clock REF_CLK, slow source clock arrives on a pin
// Notes:   waveform levels are given as select/scan codes to the analog stage
//
// Functional notes
// - six display modes, static up to 1/8 duty
// - six selectable frame frequencies per mode
// - 24 segment and 8 common outputs
// - commons four to seven only in eight-slice mode
// - segments 0-3, commons 4-7 are shared pins
// - eight-slice mode: 8 commons, 20 data segments
// - static mode: common zero, all 24 segments
// - 2/3/4 slices use commons below slice count
// - display memory fetched automatically each slice
// - generator switchable external or internal division
// - supply field bits 5:4 select generator type
// - supply register takes bit and byte writes
// - supply register resets to zero, external division
// - display register holds enable, pins, booster, mode
// - display register resets zero, bit/byte writable
// - display off deselects every segment output
// - pin control low grounds all panel pins
// - frame rate from panel clock and slices
`timescale 1ns/1ps
module lcd_segment_driver_control #(
   parameter int SEGS = 24,
   parameter int COMS = 8
) (
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   input  wire logic [15:0] ADDR,
   input  wire logic        WR_EN,
   input  wire logic [7:0]  WDATA,
   input  wire logic        BIT_EN,
   input  wire logic [2:0]  BIT_POS,
   input  wire logic        BIT_VAL,
   input  wire logic        RD_EN,
   input  wire logic        SRC_CLK_PIN,
   output logic      [7:0]  RDATA,
   output logic      [lcd_seg_pkg::SEG_LINES-1:0] FRONTPLANE_LINE,
   output logic      [lcd_seg_pkg::COM_LINES-1:0] BACKPLANE_LINE,
   output logic             FRAME_POL,
   output logic             PIN_GROUND,
   output logic             SHARED_AS_COM,
   output logic      [1:0]  SUPPLY_SEL,
   output logic             BOOST_ON
);
   import lcd_seg_pkg::*;

   if (SEGS != SEG_LINES || COMS != COM_LINES) begin : g_size_check
      $error("line counts must match the panel layout");
   end

   // ----------------------------------------
   // registers and display memory
   // ----------------------------------------
   logic [7:0] drive_supply_mode;
   logic [7:0] display_mode_reg;
   logic [7:0] panel_clock_ctrl;
   logic [7:0] disp_mem [SEG_LINES];
   logic       hit_supply;
   logic       hit_disp;
   logic       hit_clk;
   logic       hit_mem;
   logic [15:0] mem_off;
   logic [4:0] mem_idx;

   assign hit_supply = (ADDR == ADDR_SUPPLY);
   assign hit_disp   = (ADDR == ADDR_DISP);
   assign hit_clk    = (ADDR == ADDR_CLK);
   assign mem_off    = ADDR - ADDR_MEM_BASE;
   assign hit_mem    = (ADDR >= ADDR_MEM_BASE) && (mem_off < 16'(SEG_LINES));
   assign mem_idx    = mem_off[4:0];

   // byte write replaces, bit write changes one bit; unused bits forced to zero
   function automatic logic [7:0] merged(input logic [7:0] old, input logic [7:0] mask);
      logic [7:0] v;
      v = old;
      if (WR_EN) begin
         v = WDATA;
      end else if (BIT_EN) begin
         v[BIT_POS] = BIT_VAL;
      end
      return v & mask;
   endfunction : merged

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         drive_supply_mode <= RST_SUPPLY;
      end else if ((WR_EN || BIT_EN) && hit_supply) begin
         drive_supply_mode <= merged(drive_supply_mode, MASK_SUPPLY);
      end
   end
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         display_mode_reg <= RST_DISP;
      end else if ((WR_EN || BIT_EN) && hit_disp) begin
         display_mode_reg <= merged(display_mode_reg, MASK_DISP);
      end
   end
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         panel_clock_ctrl <= RST_CLK;
      end else if ((WR_EN || BIT_EN) && hit_clk) begin
         panel_clock_ctrl <= merged(panel_clock_ctrl, MASK_CLK);
      end
   end
   always_ff @(posedge REF_CLK) begin
      if ((WR_EN || BIT_EN) && hit_mem) begin
         disp_mem[mem_idx] <= merged(disp_mem[mem_idx], 8'hff);
      end
   end
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         RDATA <= 8'h00;
      end else if (RD_EN) begin
         if (hit_supply) begin
            RDATA <= drive_supply_mode;
         end else if (hit_disp) begin
            RDATA <= display_mode_reg;
         end else if (hit_clk) begin
            RDATA <= panel_clock_ctrl;
         end else if (hit_mem) begin
            RDATA <= disp_mem[mem_idx];
         end else begin
            RDATA <= 8'h00;
         end
      end
   end

   // ----------------------------------------
   // field decode
   // ----------------------------------------
   logic       disp_on;
   logic       pin_ctrl;
   logic [2:0] mode;
   logic [3:0] n_slices;
   logic       mode_ok;
   logic [2:0] src_sel;
   logic [2:0] cl_sel;
   assign disp_on  = display_mode_reg[DISP_ON_BIT];
   assign pin_ctrl = display_mode_reg[PIN_CTRL_BIT];
   assign mode     = display_mode_reg[2:0];
   assign src_sel  = panel_clock_ctrl[SRC_SEL_LSB +: 3];
   assign cl_sel   = panel_clock_ctrl[2:0];
   always_comb begin
      unique case (mode)
         MODE_SLICE8:    n_slices = 4'h8;
         MODE_SLICE4:    n_slices = 4'h4;
         MODE_SLICE3_B3: n_slices = 4'h3;
         MODE_SLICE2:    n_slices = 4'h2;
         MODE_SLICE3_B2: n_slices = 4'h3;
         MODE_STATIC:    n_slices = 4'h1;
         default:        n_slices = 4'h0;
      endcase
   end
   assign mode_ok = (n_slices != 4'h0);

   // ----------------------------------------
   // source clock pin synchroniser
   // ----------------------------------------
   logic [SYNC_STAGES-1:0] src_sync;
   logic                   src_lvl;
   logic                   pin_edge;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         src_sync <= '0;
      end else begin
         src_sync <= {src_sync[SYNC_STAGES-2:0], SRC_CLK_PIN};
      end
   end
   // level accepted only when the second and third stages agree
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         src_lvl <= 1'b0;
      end else if (src_sync[1] == src_sync[2]) begin
         src_lvl <= src_sync[2];
      end
   end
   assign pin_edge = (src_sync[1] == src_sync[2]) && src_sync[2] && !src_lvl;

   // ----------------------------------------
   // source clock selection and panel clock divider
   // ----------------------------------------
   logic [7:0] ref_cnt;
   logic [2:0] slow_cnt;
   logic [8:0] cl_cnt;
   logic [7:0] ref_mask;
   logic [8:0] cl_mask;
   logic       src_tick;
   logic       cl_tick;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ref_cnt <= 8'h00;
      end else begin
         ref_cnt <= ref_cnt + 8'h01;
      end
   end
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         slow_cnt <= 3'h0;
      end else if (pin_edge) begin
         slow_cnt <= slow_cnt + 3'h1;
      end
   end
   always_comb begin
      ref_mask = 8'((16'h1 << (REF_DIV_BASE + int'(src_sel))) - 16'h1);
      cl_mask  = 9'((16'h1 << (CL_DIV_BASE + int'(cl_sel))) - 16'h1);
      unique case (src_sel)
         3'h0:                src_tick = pin_edge;
         3'h1, 3'h2, 3'h3:    src_tick = &(ref_cnt | ~ref_mask);
         3'h4:                src_tick = pin_edge && (&slow_cnt[SLOW_DIV_EXP-1:0]);
         default:             src_tick = 1'b0;
      endcase
   end
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cl_cnt <= 9'h000;
      end else if (src_tick) begin
         cl_cnt <= cl_cnt + 9'h001;
      end
   end
   // six divide ratios, each usable in every mode
   assign cl_tick = src_tick && (int'(cl_sel) <= CL_SEL_MAX)
                    && (&(cl_cnt | ~cl_mask));

   // ----------------------------------------
   // time slice scan
   // ----------------------------------------
   logic [2:0] slice;
   logic       last_slice;

   assign last_slice = ({1'b0, slice} + 4'h1 >= n_slices);
   // one frame is n_slices panel clock periods
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         slice <= 3'h0;
      end else if (!mode_ok || {1'b0, slice} >= n_slices) begin
         slice <= 3'h0;
      end else if (cl_tick) begin
         slice <= last_slice ? 3'h0 : slice + 3'h1;
      end
   end
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         FRAME_POL <= 1'b0;
      end else if (cl_tick && mode_ok && last_slice) begin
         FRAME_POL <= !FRAME_POL;
      end
   end

   // ----------------------------------------
   // panel line drive
   // ----------------------------------------
   logic [SEG_LINES-1:0] next_front;
   logic [COM_LINES-1:0] next_back;
   logic [2:0]           scan_slice;
   // a slice left from a longer mode never lights a common this mode lacks
   assign scan_slice = ({1'b0, slice} < n_slices) ? slice : 3'h0;
   always_comb begin
      next_front = '0;
      next_back  = '0;
      if (pin_ctrl && mode_ok) begin
         next_back = COM_LINES'(1) << scan_slice;
         if (disp_on) begin
            for (int s = 0; s < SEG_LINES; s++) begin
               next_front[s] = disp_mem[s][scan_slice];
            end
            if (mode == MODE_SLICE8) begin
               next_front[3:0] = 4'h0;
            end
         end
      end
   end
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         FRONTPLANE_LINE <= '0;
         BACKPLANE_LINE  <= '0;
         PIN_GROUND      <= 1'b1;
      end else begin
         FRONTPLANE_LINE <= next_front;
         BACKPLANE_LINE  <= next_back;
         PIN_GROUND      <= !pin_ctrl;
      end
   end
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         SHARED_AS_COM <= 1'b0;
         SUPPLY_SEL    <= SUP_EXTERNAL;
         BOOST_ON      <= 1'b0;
      end else begin
         SHARED_AS_COM <= (mode == MODE_SLICE8);
         SUPPLY_SEL    <= drive_supply_mode[SUPPLY_LSB +: 2];
         BOOST_ON      <= display_mode_reg[BOOST_BIT];
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   sequence wrap_tick_s;
      cl_tick && mode_ok && last_slice && {1'b0, slice} < n_slices;
   endsequence
   sequence frame_restart_s;
      slice == 3'h0 && FRAME_POL != $past(FRAME_POL);
   endsequence
   off_deselect_a: assert property (!disp_on |=> FRONTPLANE_LINE == '0)
      else $error("segments driven while display is off");
   ground_pins_a: assert property (!pin_ctrl |=> PIN_GROUND && BACKPLANE_LINE == '0
                                   && FRONTPLANE_LINE == '0)
      else $error("pins not grounded with output control low");
   scan_onehot_a: assert property (pin_ctrl && mode_ok |=> $onehot(BACKPLANE_LINE))
      else $error("common scan not one-hot");
   static_com_a: assert property (pin_ctrl && mode == MODE_STATIC
                                  |=> BACKPLANE_LINE == 8'h01)
      else $error("static mode uses a common other than zero");
   upper_com_a: assert property (mode != MODE_SLICE8 |=> BACKPLANE_LINE[7:4] == 4'h0)
      else $error("upper commons active outside eight-slice mode");
   eight_front_a: assert property (mode == MODE_SLICE8 |=> FRONTPLANE_LINE[3:0] == 4'h0)
      else $error("shared segments carry data in eight-slice mode");
   frame_wrap_a: assert property (wrap_tick_s |=> frame_restart_s)
      else $error("frame did not restart after last slice");
   supply_read_a: assert property (RD_EN && hit_supply |=> RDATA[7:6] == 2'h0
                                   && RDATA[3:0] == 4'h0 && RDATA == $past(drive_supply_mode))
      else $error("supply register readback wrong");
   supply_out_a: assert property ((WR_EN || BIT_EN) && hit_supply
                                  |=> ##1 SUPPLY_SEL == $past(drive_supply_mode[5:4]))
      else $error("supply select output does not follow register");
endmodule : lcd_segment_driver_control

// [verification/panel_glass_model.sv]
// Purpose: passive segment panel seen from its frontplane and backplane pins
// Assumes: one common active at a time while scanning
// Notes:   records commons used and the segment data shown on each common
`timescale 1ns/1ps
module panel_glass_model (
   input  wire logic        clk,
   input  wire logic        clear,
   input  wire logic [23:0] frontplane,
   input  wire logic [7:0]  backplane,
   input  wire logic        ground,
   output logic      [7:0]  seen_coms,
   output logic             any_lit,
   output logic             multi_hot,
   output logic      [23:0] cap [8]
);
   // ------------------------------------------------
   // scan bookkeeping
   // ------------------------------------------------
   always_ff @(posedge clk) begin
      if (clear) begin
         seen_coms <= 8'h00;
         any_lit   <= 1'b0;
         multi_hot <= 1'b0;
      end else if (!ground) begin
         seen_coms <= seen_coms | backplane;
         any_lit   <= any_lit | (|frontplane);
         if ($countones(backplane) > 1) begin
            multi_hot <= 1'b1;
         end
      end
   end
   // ------------------------------------------------
   // pixel capture per active common
   // ------------------------------------------------
   always_ff @(posedge clk) begin
      for (int k = 0; k < 8; k++) begin
         if (backplane[k] && !ground) begin
            cap[k] <= frontplane;
         end
      end
   end
endmodule : panel_glass_model

// [verification/tb_lcd_segment_driver_control.sv]
// Purpose: self-checking bench for the segment panel controller
// Assumes: source select 001 and clock select 0 give a 1024-cycle slice
// Notes:   reserved supply bits are set once only to prove they read back zero
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_lcd_segment_driver_control;
   import lcd_seg_pkg::*;
   logic        REF_CLK = 1'b0;
   logic        RST_N = 1'b0;
   logic [15:0] ADDR = 16'h0000;
   logic        WR_EN = 1'b0;
   logic [7:0]  WDATA = 8'h00;
   logic        BIT_EN = 1'b0;
   logic [2:0]  BIT_POS = 3'h0;
   logic        BIT_VAL = 1'b0;
   logic        RD_EN = 1'b0;
   logic        CLR = 1'b1;
   logic        SRC_PIN = 1'b0;
   logic [7:0]  RDATA;
   logic [23:0] FRONTPLANE_LINE;
   logic [7:0]  BACKPLANE_LINE;
   logic        FRAME_POL, PIN_GROUND, SHARED_AS_COM, BOOST_ON;
   logic [1:0]  SUPPLY_SEL;
   logic [7:0]  seen_coms;
   logic        any_lit, multi_hot;
   logic [23:0] cap [8];
   int          failures = 0;
   int          tests_run = 0;
   int          cnt;
   logic [2:0]  modes [6] = '{MODE_SLICE8, MODE_SLICE4, MODE_SLICE3_B3,
                               MODE_SLICE2, MODE_SLICE3_B2, MODE_STATIC};
   int          slices [6] = '{8, 4, 3, 2, 3, 1};
   logic [7:0]  sups [3] = '{8'h00, 8'h10, 8'h30};
   logic [7:0]  clk_codes [6] = '{8'h11, 8'h12, 8'h00, 8'h20, 8'h30, 8'h40};
   int          frame_len [6] = '{2048, 4096, 256, 2048, 4096, 2048};
   always #5 REF_CLK = ~REF_CLK;
   // slow source pin: one rising edge every 16 reference cycles
   always begin
      repeat (8) @(posedge REF_CLK);
      #1 SRC_PIN = ~SRC_PIN;
   end
   lcd_segment_driver_control #(.SEGS(24), .COMS(8)) i_lcd_segment_driver_control (
      .REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR), .WR_EN(WR_EN), .WDATA(WDATA),
      .BIT_EN(BIT_EN), .BIT_POS(BIT_POS), .BIT_VAL(BIT_VAL), .RD_EN(RD_EN),
      .SRC_CLK_PIN(SRC_PIN), .RDATA(RDATA), .FRONTPLANE_LINE(FRONTPLANE_LINE),
      .BACKPLANE_LINE(BACKPLANE_LINE), .FRAME_POL(FRAME_POL), .PIN_GROUND(PIN_GROUND),
      .SHARED_AS_COM(SHARED_AS_COM), .SUPPLY_SEL(SUPPLY_SEL), .BOOST_ON(BOOST_ON));
   panel_glass_model i_panel_glass_model (
      .clk(REF_CLK), .clear(CLR), .frontplane(FRONTPLANE_LINE),
      .backplane(BACKPLANE_LINE), .ground(PIN_GROUND), .seen_coms(seen_coms),
      .any_lit(any_lit), .multi_hot(multi_hot), .cap(cap));
   // ------------------------------------------------
   // access tasks
   // ------------------------------------------------
   task automatic end_sim;
      if (failures == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   task automatic cyc(input int n);
      repeat (n) @(posedge REF_CLK);
      #1;
   endtask : cyc
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      ADDR  = a;
      WDATA = d;
      WR_EN = 1'b1;
      cyc(1);
      WR_EN = 1'b0;
      cyc(1);
   endtask : wr
   task automatic bw(input logic [15:0] a, input logic [2:0] p, input logic v);
      ADDR    = a;
      BIT_POS = p;
      BIT_VAL = v;
      BIT_EN  = 1'b1;
      cyc(1);
      BIT_EN  = 1'b0;
      cyc(1);
   endtask : bw
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      ADDR  = a;
      RD_EN = 1'b1;
      cyc(1);
      RD_EN = 1'b0;
      cyc(1);
      `CHK(RDATA, exp)
   endtask : rd
   task automatic wait_pol(output int n);
      logic p;
      p = FRAME_POL;
      n = 0;
      while (FRAME_POL === p && n < 40000) begin
         cyc(1);
         n++;
      end
      if (n >= 40000) begin
         failures++;
         end_sim();
      end
   endtask : wait_pol
   function automatic logic [7:0] mem_val(input int s);
      return 8'(s * 37 + 19);
   endfunction : mem_val
   // one frame of a mode: period, commons used and pixels per common
   task automatic run_mode(input logic [2:0] mode, input int n);
      logic [23:0] exp;
      logic [7:0]  b;
      wr(ADDR_DISP, 8'hc0 | {5'h00, mode});
      CLR = 1'b1;
      wait_pol(cnt);
      CLR = 1'b0;
      wait_pol(cnt);
      `CHK(cnt, n * 1024)
      `CHK(seen_coms, 8'((1 << n) - 1))
      `CHK(multi_hot, 1'b0)
      `CHK(SHARED_AS_COM, mode == MODE_SLICE8)
      for (int k = 0; k < n; k++) begin
         for (int s = 0; s < 24; s++) begin
            b      = mem_val(s);
            exp[s] = (mode == MODE_SLICE8 && s < 4) ? 1'b0 : b[k];
         end
         `CHK(cap[k], exp)
      end
   endtask : run_mode
   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      cyc(20);
      RST_N = 1'b1;
      rd(ADDR_SUPPLY, 8'h00);
      rd(ADDR_DISP, 8'h00);
      `CHK(PIN_GROUND, 1'b1)
      wr(ADDR_SUPPLY, 8'hcf);
      rd(ADDR_SUPPLY, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_SUPPLY, sups[i]);
         rd(ADDR_SUPPLY, sups[i]);
         cyc(2);
         `CHK(SUPPLY_SEL, sups[i][5:4])
      end
      wr(ADDR_SUPPLY, 8'h00);
      bw(ADDR_SUPPLY, 3'h4, 1'b1);
      rd(ADDR_SUPPLY, 8'h10);
      bw(ADDR_SUPPLY, 3'h5, 1'b1);
      rd(ADDR_SUPPLY, 8'h30);
      cyc(2);
      `CHK(SUPPLY_SEL, SUP_INT_STEP)
      wr(ADDR_DISP, 8'hff);
      rd(ADDR_DISP, 8'hd7);
      `CHK(BOOST_ON, 1'b1)
      bw(ADDR_DISP, 3'h4, 1'b0);
      rd(ADDR_DISP, 8'hc7);
      `CHK(BOOST_ON, 1'b0)
      for (int s = 0; s < 24; s++) begin
         wr(ADDR_MEM_BASE + 16'(s), mem_val(s));
      end
      wr(ADDR_CLK, 8'h10);
      for (int i = 0; i < 6; i++) begin
         run_mode(modes[i], slices[i]);
      end
      for (int c = 0; c < 6; c++) begin
         wr(ADDR_CLK, clk_codes[c]);
         CLR = 1'b1;
         wait_pol(cnt);
         CLR = 1'b0;
         wait_pol(cnt);
         `CHK(cnt, frame_len[c])
      end
      wr(ADDR_CLK, 8'h10);
      wr(ADDR_DISP, 8'h40 | {5'h00, MODE_SLICE2});
      CLR = 1'b1;
      cyc(3);
      CLR = 1'b0;
      `CHK(PIN_GROUND, 1'b0)
      cyc(2100);
      `CHK(seen_coms, 8'h03)
      `CHK(any_lit, 1'b0)
      wr(ADDR_DISP, {5'h00, MODE_SLICE2});
      cyc(3);
      `CHK(PIN_GROUND, 1'b1)
      end_sim();
   end
endmodule : tb_lcd_segment_driver_control
